//--- hpe_consts.svh
// Function
// - events stay inside the port's own partition
// - six enabled slot flags plus master raise interrupt
// - msi if enabled, else intx unless disabled
// - d3hot: rising enabled flag sends wakeup message
// - wakeup ignores the hot-plug master enable
// - pending interrupt fires after d3hot to d0
// - legacy event output serves partition 0 only
// - legacy routed port: no intx, msi, pme
// - legacy output reaches pin only in alternate function
// - legacy status set only for legacy routed ports
// - legacy routing leaves slot bits untouched
// - d3hot to d0 keeps context, flag says so
// - switch low power: upstream d3hot plus turnoff acked
// - d0 drives link l0, d3hot drives l1
// - upstream port asks l1 once all functions d3hot
// - downstream port accepts partner d3hot l1 request
// - reset d0u, config d0a, d3 write, d0 write
// - d3hot: type 0 config and bridge messages accepted
// - d3hot: other primary and all secondary requests unsupported
// - d3hot: tlp errors reported, others silently dropped
// - d3hot: completions to bridge are unexpected
// - d3hot: passing completions routed, link woken
//
// constants of the hot-plug event and power state block
// assumes a byte-addressed avalon slave with an 8-bit address
`ifndef HPE_CONSTS_SVH
`define HPE_CONSTS_SVH

// ==========================================================
// widths
`define HPE_PORT_W 3
`define HPE_PART_W 2
`define HPE_NEV 6

// ==========================================================
// register map
`define HPE_GLB_BIT 7
`define HPE_PORT_HI 6
`define HPE_PORT_LO 4
`define HPE_IDX_HI 3
`define HPE_IDX_LO 2
`define HPE_IDX_SLOT_CTL 2'h0
`define HPE_IDX_SLOT_STS 2'h1
`define HPE_IDX_PM_CSR 2'h2
`define HPE_IDX_CMD 2'h3
`define HPE_ADR_LEG_CTL 8'h80
`define HPE_ADR_LEG_STS 8'h84
`define HPE_ADR_PIN_CFG 8'h88
`define HPE_ADR_SW_STS 8'h8c

// ==========================================================
// field positions
`define HPE_SC_MASTER 8
`define HPE_PM_CTX_KEPT 3
`define HPE_PM_WAKE_EN 8
`define HPE_CMD_CONFIG 2
`define HPE_CMD_INTX_DIS 10
`define HPE_CMD_MSI_EN 16
`define HPE_CMD_ASPM_OK 18
`define HPE_CMD_PART_LO 24
`define HPE_PIN_ALT 0
`define HPE_PIN_DATA 1
`define HPE_PIN_OE 2
`define HPE_SW_LOWPWR 0
`define HPE_SW_UPL1 1

// ==========================================================
// codes and reset values
`define HPE_PS_D0 2'h0
`define HPE_PS_D3H 2'h3
`define HPE_CTX_KEPT_RST 1'h1
`define HPE_LEG_PART 2'h0

`endif

//--- hpe_hotplug_pm.sv
// hot-plug event notification and bridge function power states
// assumes event, link and tlp inputs come from logic on clk
`timescale 1ns/10ps
`include "hpe_consts.svh"

module hpe_hotplug_pm
  import hpe_pkg::*;
#(
  parameter int NPORTS = 8,
  parameter int NPART = 4,
  parameter int NUPF = 1
)
(
  input wire logic clk, // core clock, 100 MHz
  input wire logic rstn, // async reset, active low
  input wire logic [7:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic [NPORTS-1:0][`HPE_NEV-1:0] slot_event, // slot flag set pulses
  input wire logic [NPORTS-1:0] partner_l1_req, // partner asks for l1
  input wire logic [NPORTS-1:0] partner_l1_pm, // request caused by partner d3hot
  input wire logic [NPORTS-1:0] err_report_en, // error reporting enabled
  input wire logic [NUPF-1:0] up_fn_d3hot, // upstream functions in d3hot
  input wire logic turnoff_acked, // turn-off handshake complete
  input wire logic tlp_valid, // tlp presented
  input wire hpe_tlp_req_type tlp_req, // tlp class and port
  output logic [NPART-1:0] intx_part, // intx level per partition
  output logic [NPORTS-1:0] msi_req, // msi send pulse
  output logic [NPORTS-1:0] pme_req, // wakeup message pulse
  output logic [NPORTS-1:0] link_to_l0, // link target l0
  output logic [NPORTS-1:0] link_to_l1, // link target l1
  output logic [NPORTS-1:0] l1_accept, // accept partner l1 request
  output logic up_l1_req, // upstream port l1 entry
  output logic switch_low_power, // switch in low power
  output logic legacy_event_out, // legacy general purpose event
  output logic gpio_pin_o, // shared pin value
  output logic gpio_pin_oe, // shared pin drive enable
  output logic tlp_resp_valid, // disposition pulse
  output hpe_tlp_resp_type tlp_resp // disposition
);

  // ==========================================================
  // state
  typedef struct packed {
    hpe_port_type [NPORTS-1:0] port;
    logic [NPORTS-1:0] leg_ctl;
    logic [NPORTS-1:0] leg_sts;
    logic pin_alt;
    logic pin_data;
    logic pin_oe;
    logic [NPART-1:0] intx;
    logic up_l1;
    logic low_power;
    logic leg_out;
    logic gpio_o;
    logic gpio_oe;
    // bus side
    logic waitreq;
    logic [31:0] rdata;
    // tlp side
    logic resp_valid;
    hpe_tlp_resp_type resp;
  } hpe_state_type;

  hpe_state_type st_r;
  hpe_state_type st_nxt;

  // ==========================================================
  // combinational next state
  always_comb
  begin
    // bus helpers
    logic acc;
    logic wr;
    logic glb;
    logic [`HPE_PORT_W-1:0] pidx;
    logic [1:0] ridx;
    // per port helpers
    logic leg;
    logic d3;
    logic cond;
    logic [`HPE_NEV-1:0] clr;
    logic [`HPE_NEV-1:0] newly;
    logic [1:0] wstate;
    // tlp helpers
    logic tlp_d3;
    logic tlp_l1;
    logic tlp_rep;
    hpe_port_type q;

    // defaults, no latches
    acc = 1'b0;
    wr = 1'b0;
    glb = 1'b0;
    pidx = '0;
    ridx = 2'h0;
    leg = 1'b0;
    d3 = 1'b0;
    cond = 1'b0;
    clr = '0;
    newly = '0;
    wstate = 2'h0;
    tlp_d3 = 1'b0;
    tlp_l1 = 1'b0;
    tlp_rep = 1'b0;
    q = '0;

    // every register holds unless told
    st_nxt = st_r;

    // bus decode: the access acts in the cycle waitrequest is high
    acc = (avs_read | avs_write) & st_r.waitreq;
    wr = acc & avs_write;
    glb = avs_address[`HPE_GLB_BIT];
    pidx = avs_address[`HPE_PORT_HI:`HPE_PORT_LO];
    ridx = avs_address[`HPE_IDX_HI:`HPE_IDX_LO];
    wstate = avs_writedata[1:0];
    // waitrequest low for one cycle answers
    st_nxt.waitreq = ~acc;
    // intx rebuilt every cycle
    st_nxt.intx = '0;

    // legacy status clear first, so a set below wins
    if (wr && glb && (avs_address == `HPE_ADR_LEG_STS))
    begin
      st_nxt.leg_sts = st_r.leg_sts & ~avs_writedata[NPORTS-1:0];
    end

    // per port event, interrupt and power logic
    for (int p = 0; p < NPORTS; p++)
    begin
      q = st_r.port[p];
      clr = '0;
      if (wr && !glb && (int'(pidx) == p) && (ridx == `HPE_IDX_SLOT_STS))
      begin
        clr = avs_writedata[`HPE_NEV-1:0];
      end
      // set wins over software clear
      st_nxt.port[p].sts = (q.sts & ~clr) | slot_event[p];
      newly = slot_event[p] & ~q.sts & q.en;
      leg = st_r.leg_ctl[p] && (q.part == `HPE_LEG_PART);
      d3 = (q.fstate == HPE_D3H);

      // interrupt condition held off in d3hot, so it fires on return to d0
      cond = (|(q.sts & q.en)) & q.master & ~d3 & ~leg;
      st_nxt.port[p].irq_prev = cond;
      st_nxt.port[p].msi_req = cond & ~q.irq_prev & q.msi_en;
      if (cond && !q.msi_en && !q.intx_dis && (int'(q.part) < NPART))
      begin
        st_nxt.intx[q.part] = 1'b1;
      end

      // wakeup does not look at the master enable
      st_nxt.port[p].pme_req = d3 & q.wake_en & (|newly) & ~leg;
      if (leg && (|newly))
      begin
        st_nxt.leg_sts[p] = 1'b1;
      end

      // function state machine
      if (wr && !glb && (int'(pidx) == p))
      begin
        if (ridx == `HPE_IDX_SLOT_CTL)
        begin
          st_nxt.port[p].en = avs_writedata[`HPE_NEV-1:0];
          st_nxt.port[p].master = avs_writedata[`HPE_SC_MASTER];
        end
        if (ridx == `HPE_IDX_PM_CSR)
        begin
          st_nxt.port[p].wake_en = avs_writedata[`HPE_PM_WAKE_EN];
          // state change keeps every other register as it is
          if ((q.fstate == HPE_D0A) && (wstate == `HPE_PS_D3H))
          begin
            st_nxt.port[p].fstate = HPE_D3H;
          end
          if (d3 && (wstate == `HPE_PS_D0))
          begin
            st_nxt.port[p].fstate = HPE_D0U;
          end
        end
        if (ridx == `HPE_IDX_CMD)
        begin
          st_nxt.port[p].intx_dis = avs_writedata[`HPE_CMD_INTX_DIS];
          st_nxt.port[p].msi_en = avs_writedata[`HPE_CMD_MSI_EN];
          st_nxt.port[p].aspm_ok = avs_writedata[`HPE_CMD_ASPM_OK];
          st_nxt.port[p].part = avs_writedata[`HPE_CMD_PART_LO +: `HPE_PART_W];
          if ((q.fstate == HPE_D0U) && avs_writedata[`HPE_CMD_CONFIG])
          begin
            st_nxt.port[p].fstate = HPE_D0A;
          end
        end
      end

      // link target follows the function state
      st_nxt.port[p].link_l0 = (st_nxt.port[p].fstate != HPE_D3H);
      st_nxt.port[p].link_l1 = (st_nxt.port[p].fstate == HPE_D3H);
      st_nxt.port[p].l1_accept = partner_l1_req[p] & (partner_l1_pm[p] | q.aspm_ok);
    end

    // global registers
    if (wr && glb && (avs_address == `HPE_ADR_LEG_CTL))
    begin
      st_nxt.leg_ctl = avs_writedata[NPORTS-1:0];
    end
    if (wr && glb && (avs_address == `HPE_ADR_PIN_CFG))
    begin
      st_nxt.pin_alt = avs_writedata[`HPE_PIN_ALT];
      st_nxt.pin_data = avs_writedata[`HPE_PIN_DATA];
      st_nxt.pin_oe = avs_writedata[`HPE_PIN_OE];
    end

    // legacy output is the or of its status
    st_nxt.leg_out = |st_r.leg_sts;
    // pin carries the event only in alternate function
    st_nxt.gpio_o = st_r.pin_alt ? st_r.leg_out : st_r.pin_data;
    st_nxt.gpio_oe = st_r.pin_alt | st_r.pin_oe;

    // upstream port and switch power
    st_nxt.up_l1 = &up_fn_d3hot;
    st_nxt.low_power = up_fn_d3hot[0] & turnoff_acked;

    // read data
    st_nxt.rdata = '0;
    if (acc && avs_read)
    begin
      // per port registers
      if (!glb && (int'(pidx) < NPORTS))
      begin
        q = st_r.port[pidx];
        unique case (ridx)
          `HPE_IDX_SLOT_CTL:
          begin
            st_nxt.rdata[`HPE_NEV-1:0] = q.en;
            st_nxt.rdata[`HPE_SC_MASTER] = q.master;
          end
          `HPE_IDX_SLOT_STS:
          begin
            st_nxt.rdata[`HPE_NEV-1:0] = q.sts;
          end
          `HPE_IDX_PM_CSR:
          begin
            st_nxt.rdata[1:0] = (q.fstate == HPE_D3H) ? `HPE_PS_D3H : `HPE_PS_D0;
            st_nxt.rdata[`HPE_PM_CTX_KEPT] = `HPE_CTX_KEPT_RST;
            st_nxt.rdata[`HPE_PM_WAKE_EN] = q.wake_en;
          end
          `HPE_IDX_CMD:
          begin
            st_nxt.rdata[`HPE_CMD_CONFIG] = (q.fstate != HPE_D0U);
            st_nxt.rdata[`HPE_CMD_INTX_DIS] = q.intx_dis;
            st_nxt.rdata[`HPE_CMD_MSI_EN] = q.msi_en;
            st_nxt.rdata[`HPE_CMD_ASPM_OK] = q.aspm_ok;
            st_nxt.rdata[`HPE_CMD_PART_LO +: `HPE_PART_W] = q.part;
          end
        endcase
      end
      // global registers
      else if (avs_address == `HPE_ADR_LEG_CTL)
      begin
        st_nxt.rdata[NPORTS-1:0] = st_r.leg_ctl;
      end
      else if (avs_address == `HPE_ADR_LEG_STS)
      begin
        st_nxt.rdata[NPORTS-1:0] = st_r.leg_sts;
      end
      else if (avs_address == `HPE_ADR_PIN_CFG)
      begin
        st_nxt.rdata[`HPE_PIN_ALT] = st_r.pin_alt;
        st_nxt.rdata[`HPE_PIN_DATA] = st_r.pin_data;
        st_nxt.rdata[`HPE_PIN_OE] = st_r.pin_oe;
      end
      else if (avs_address == `HPE_ADR_SW_STS)
      begin
        st_nxt.rdata[`HPE_SW_LOWPWR] = st_r.low_power;
        st_nxt.rdata[`HPE_SW_UPL1] = st_r.up_l1;
      end
    end

    // tlp disposition, one cycle after presentation
    st_nxt.resp_valid = tlp_valid;
    st_nxt.resp.port = tlp_req.port;
    st_nxt.resp.wake_l0 = 1'b0;
    st_nxt.resp.action = HPE_A_ACCEPT;
    // addressed port state
    if (int'(tlp_req.port) < NPORTS)
    begin
      tlp_d3 = (st_r.port[tlp_req.port].fstate == HPE_D3H);
      tlp_l1 = st_r.port[tlp_req.port].link_l1;
      tlp_rep = err_report_en[tlp_req.port];
    end

    // d3hot narrows what is taken
    unique case (tlp_req.kind)
      HPE_K_CFG0, HPE_K_MSG_BRIDGE:
      begin
        st_nxt.resp.action = HPE_A_ACCEPT;
      end
      HPE_K_REQ_PRI, HPE_K_REQ_SEC:
      begin
        st_nxt.resp.action = tlp_d3 ? HPE_A_UR : HPE_A_ROUTE;
      end
      HPE_K_CPL_BRIDGE:
      begin
        st_nxt.resp.action = tlp_d3 ? HPE_A_UC : HPE_A_ACCEPT;
      end
      HPE_K_CPL_PASS:
      begin
        st_nxt.resp.action = HPE_A_ROUTE;
        st_nxt.resp.wake_l0 = tlp_d3 & tlp_l1;
      end
      HPE_K_ERR_TLP:
      begin
        st_nxt.resp.action = tlp_rep ? HPE_A_REPORT : HPE_A_DISCARD;
        st_nxt.resp.wake_l0 = tlp_d3 & tlp_l1 & tlp_rep;
      end
      HPE_K_ERR_OTHER:
      begin
        st_nxt.resp.action = (tlp_d3 || !tlp_rep) ? HPE_A_DISCARD : HPE_A_REPORT;
      end
    endcase

    // no link wake without a tlp
    if (!tlp_valid)
    begin
      st_nxt.resp.wake_l0 = 1'b0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= '0;
      st_r.waitreq <= 1'b1;
      // ports restart in d0 uninitialized at l0
      for (int p = 0; p < NPORTS; p++)
      begin
        st_r.port[p].fstate <= HPE_D0U;
        st_r.port[p].link_l0 <= 1'b1;
      end
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  always_comb
  begin
    for (int p = 0; p < NPORTS; p++)
    begin
      msi_req[p] = st_r.port[p].msi_req;
      pme_req[p] = st_r.port[p].pme_req;
      link_to_l0[p] = st_r.port[p].link_l0;
      link_to_l1[p] = st_r.port[p].link_l1;
      l1_accept[p] = st_r.port[p].l1_accept;
    end
  end

  // flop outputs straight to ports
  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.waitreq;
  assign intx_part = st_r.intx;
  assign up_l1_req = st_r.up_l1;
  assign switch_low_power = st_r.low_power;
  assign legacy_event_out = st_r.leg_out;
  assign gpio_pin_o = st_r.gpio_o;
  assign gpio_pin_oe = st_r.gpio_oe;
  assign tlp_resp_valid = st_r.resp_valid;
  assign tlp_resp = st_r.resp;

endmodule

//--- hpe_hotplug_pm_sva.sv
// assertions on the ports of the hot-plug power block
// assumes it is bound to hpe_hotplug_pm
`timescale 1ns/10ps
module hpe_hotplug_pm_sva
  import hpe_pkg::*;
#(
  parameter int NPORTS = 8,
  parameter int NUPF = 1
)
(
  input wire logic clk, // core clock
  input wire logic rstn, // reset, active low
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic avs_waitrequest, // stall
  input wire logic [NPORTS-1:0] partner_l1_req, // l1 ask
  input wire logic [NPORTS-1:0] partner_l1_pm, // ask from d3hot
  input wire logic [NUPF-1:0] up_fn_d3hot, // upstream d3hot
  input wire logic turnoff_acked, // turn-off done
  input wire logic tlp_valid, // tlp strobe
  input wire hpe_tlp_req_type tlp_req, // tlp
  input wire logic [NPORTS-1:0] msi_req, // msi pulse
  input wire logic [NPORTS-1:0] pme_req, // wakeup pulse
  input wire logic [NPORTS-1:0] link_to_l0, // target l0
  input wire logic [NPORTS-1:0] link_to_l1, // target l1
  input wire logic [NPORTS-1:0] l1_accept, // l1 accepted
  input wire logic up_l1_req, // upstream l1
  input wire logic switch_low_power, // low power
  input wire logic tlp_resp_valid, // disposition strobe
  input wire hpe_tlp_resp_type tlp_resp // disposition
);
  // ==========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_ack_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_resp; tlp_valid |=> tlp_resp_valid && tlp_resp.port == $past(tlp_req.port); endproperty
  property p_cfg0; tlp_valid && tlp_req.kind == HPE_K_CFG0 |=> tlp_resp.action == HPE_A_ACCEPT; endproperty
  property p_cpl; tlp_valid && tlp_req.kind == HPE_K_CPL_PASS |=> tlp_resp.action == HPE_A_ROUTE; endproperty
  property p_l1acc; rstn && partner_l1_req[0] && partner_l1_pm[0] |=> l1_accept[0]; endproperty
  property p_upl1; rstn |=> up_l1_req == $past(&up_fn_d3hot); endproperty
  property p_lowpwr; rstn && up_fn_d3hot[0] && turnoff_acked |=> switch_low_power; endproperty
  property p_lowpwr_off; !turnoff_acked |=> !switch_low_power; endproperty
  property p_pme_msi; !(pme_req[0] && msi_req[0]); endproperty
  property p_link; !(link_to_l0[0] && link_to_l1[0]); endproperty
  property p_wake; tlp_resp_valid && tlp_resp.wake_l0 |-> link_to_l1[tlp_resp.port]; endproperty

  a_ack: assert property (p_ack) else $error("no answer to bus request");
  a_ack_one: assert property (p_ack_one) else $error("waitrequest low too long");
  a_resp: assert property (p_resp) else $error("tlp disposition late or wrong port");
  a_cfg0: assert property (p_cfg0) else $error("config tlp not accepted");
  a_cpl: assert property (p_cpl) else $error("passing completion not routed");
  a_l1acc: assert property (p_l1acc) else $error("partner l1 request refused");
  a_upl1: assert property (p_upl1) else $error("upstream l1 request wrong");
  a_lowpwr: assert property (p_lowpwr) else $error("switch not in low power");
  a_lowpwr_off: assert property (p_lowpwr_off) else $error("low power without turn-off");
  a_pme_msi: assert property (p_pme_msi) else $error("wakeup and msi together");
  a_link: assert property (p_link) else $error("link target l0 and l1 together");
  a_wake: assert property (p_wake) else $error("link wake while not in l1");

  // ==========================================
  // coverage
  c_ur: cover property (tlp_resp_valid && tlp_resp.action == HPE_A_UR);
  c_pme: cover property (pme_req[0]);
  c_l1: cover property (l1_accept[0]);
  c_wake: cover property (tlp_resp.wake_l0);
endmodule

bind hpe_hotplug_pm hpe_hotplug_pm_sva #(.NPORTS(NPORTS), .NUPF(NUPF)) sva_i (.clk(clk), .rstn(rstn),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .partner_l1_req(partner_l1_req), .partner_l1_pm(partner_l1_pm), .up_fn_d3hot(up_fn_d3hot),
  .turnoff_acked(turnoff_acked), .tlp_valid(tlp_valid), .tlp_req(tlp_req), .msi_req(msi_req),
  .pme_req(pme_req), .link_to_l0(link_to_l0), .link_to_l1(link_to_l1), .l1_accept(l1_accept),
  .up_l1_req(up_l1_req), .switch_low_power(switch_low_power), .tlp_resp_valid(tlp_resp_valid),
  .tlp_resp(tlp_resp));

//--- hpe_pkg.sv
// types of the hot-plug event and power state block
// assumes hpe_consts.svh is on the include path
`include "hpe_consts.svh"

package hpe_pkg;

  // function power state
  typedef enum logic [1:0] {
    HPE_D0U = 2'b00,
    HPE_D0A = 2'b01,
    HPE_D3H = 2'b10
  } hpe_fstate_type;

  // class of a tlp or error presented for disposition
  typedef enum logic [2:0] {
    HPE_K_CFG0 = 3'b000,
    HPE_K_MSG_BRIDGE = 3'b001,
    HPE_K_REQ_PRI = 3'b010,
    HPE_K_REQ_SEC = 3'b011,
    HPE_K_CPL_BRIDGE = 3'b100,
    HPE_K_CPL_PASS = 3'b101,
    HPE_K_ERR_TLP = 3'b110,
    HPE_K_ERR_OTHER = 3'b111
  } hpe_kind_type;

  // what is done with it
  typedef enum logic [2:0] {
    HPE_A_ACCEPT = 3'b000,
    HPE_A_UR = 3'b001,
    HPE_A_UC = 3'b010,
    HPE_A_ROUTE = 3'b011,
    HPE_A_REPORT = 3'b100,
    HPE_A_DISCARD = 3'b101
  } hpe_action_type;

  typedef struct packed {
    hpe_kind_type kind;
    logic [`HPE_PORT_W-1:0] port;
  } hpe_tlp_req_type;

  typedef struct packed {
    hpe_action_type action;
    logic wake_l0;
    logic [`HPE_PORT_W-1:0] port;
  } hpe_tlp_resp_type;

  // per downstream port state
  typedef struct packed {
    logic [`HPE_NEV-1:0] sts;
    logic [`HPE_NEV-1:0] en;
    logic master;
    logic wake_en;
    logic intx_dis;
    logic msi_en;
    logic aspm_ok;
    logic [`HPE_PART_W-1:0] part;
    hpe_fstate_type fstate;
    logic irq_prev;
    logic msi_req;
    logic pme_req;
    logic link_l0;
    logic link_l1;
    logic l1_accept;
  } hpe_port_type;

endpackage

//--- hpe_rc_model.sv
// root complex and link partner model for the hot-plug power block
// assumes the block samples tlp and l1 inputs on the rising clk edge
`timescale 1ns/10ps
module hpe_rc_model
  import hpe_pkg::*;
(
  input wire logic clk, // core clock
  output logic tlp_valid, // tlp strobe
  output hpe_tlp_req_type tlp_req, // tlp class and port
  output logic [7:0] partner_l1_req, // partner asks for l1
  output logic [7:0] partner_l1_pm, // ask caused by d3hot
  output logic [7:0] err_report_en, // error reporting on
  input wire logic tlp_resp_valid, // disposition strobe
  input wire hpe_tlp_resp_type tlp_resp // disposition
);
  // ==========================================
  // idle levels
  initial
  begin
    tlp_valid = 1'b0;
    tlp_req = '0;
    partner_l1_req = '0;
    partner_l1_pm = '0;
    err_report_en = '1;
  end

  // one tlp; the answer stands in the cycle after it is taken
  task automatic send(input hpe_kind_type k, input logic [2:0] p, output hpe_action_type a);
    @(posedge clk);
    tlp_valid <= 1'b1;
    tlp_req <= '{kind: k, port: p};
    @(posedge clk);
    tlp_valid <= 1'b0;
    tlp_req <= '{kind: hpe_kind_type'(~k), port: ~p}; // no stale class after release
    @(posedge clk);
    a = tlp_resp_valid ? tlp_resp.action : hpe_action_type'(3'h7);
  endtask

  // partner enters d3hot and asks its link into l1
  task automatic enter_d3(input logic [2:0] p);
    @(posedge clk);
    partner_l1_pm[p] <= 1'b1;
    partner_l1_req[p] <= 1'b1;
  endtask
endmodule

//--- tb.sv
// self-checking bench of the hot-plug power block
// assumes hpe_rc_model stands on the link side
`timescale 1ns/10ps
`include "hpe_consts.svh"
module tb;
  import hpe_pkg::*;
  typedef struct packed {hpe_kind_type k; hpe_action_type a;} hpe_row_type;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [7:0][5:0] slot_event = '0;
  logic [0:0] up_fn_d3hot = '0;
  logic turnoff_acked = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, up_l1_req, switch_low_power, legacy_event_out, gpio_pin_o, gpio_pin_oe;
  logic tlp_valid, tlp_resp_valid;
  logic [3:0] intx_part;
  logic [7:0] msi_req, pme_req, link_to_l0, link_to_l1, l1_accept, partner_l1_req, partner_l1_pm, err_report_en;
  hpe_tlp_req_type tlp_req;
  hpe_tlp_resp_type tlp_resp;
  hpe_action_type act;
  int failures = 0;
  int n_compared = 0;
  int n_msi = 0;
  int n_pme = 0;
  int m;
  hpe_row_type rows [8] = '{'{HPE_K_CFG0, HPE_A_ACCEPT}, '{HPE_K_MSG_BRIDGE, HPE_A_ACCEPT},
    '{HPE_K_REQ_PRI, HPE_A_UR}, '{HPE_K_REQ_SEC, HPE_A_UR}, '{HPE_K_CPL_BRIDGE, HPE_A_UC},
    '{HPE_K_CPL_PASS, HPE_A_ROUTE}, '{HPE_K_ERR_TLP, HPE_A_REPORT}, '{HPE_K_ERR_OTHER, HPE_A_DISCARD}};

  // ==========================================
  // clock, pulse counters, parts
  always #5 clk = ~clk;

  // count message pulses of all ports
  always @(posedge clk)
  begin
    n_msi <= n_msi + $countones(msi_req);
    n_pme <= n_pme + $countones(pme_req);
  end

  hpe_hotplug_pm hpe_hotplug_pm_i (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .slot_event(slot_event), .partner_l1_req(partner_l1_req),
    .partner_l1_pm(partner_l1_pm), .err_report_en(err_report_en), .up_fn_d3hot(up_fn_d3hot),
    .turnoff_acked(turnoff_acked), .tlp_valid(tlp_valid), .tlp_req(tlp_req), .intx_part(intx_part),
    .msi_req(msi_req), .pme_req(pme_req), .link_to_l0(link_to_l0), .link_to_l1(link_to_l1),
    .l1_accept(l1_accept), .up_l1_req(up_l1_req), .switch_low_power(switch_low_power),
    .legacy_event_out(legacy_event_out), .gpio_pin_o(gpio_pin_o), .gpio_pin_oe(gpio_pin_oe),
    .tlp_resp_valid(tlp_resp_valid), .tlp_resp(tlp_resp));

  hpe_rc_model hpe_rc_model_i (.clk(clk), .tlp_valid(tlp_valid), .tlp_req(tlp_req),
    .partner_l1_req(partner_l1_req), .partner_l1_pm(partner_l1_pm), .err_report_en(err_report_en),
    .tlp_resp_valid(tlp_resp_valid), .tlp_resp(tlp_resp));

  // ==========================================
  // tasks
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(n, q, e);
  endtask

  // one-cycle flag pulse, then time for the notification to land
  task automatic ev(input int p, input int k);
    @(posedge clk);
    slot_event[p][k] <= 1'b1;
    @(posedge clk);
    slot_event <= '0;
    repeat (4) @(posedge clk);
  endtask

  task automatic final_report;
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #300us;
    failures++;
    final_report();
  end

  // ==========================================
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rdc("pm_csr", 8'h08, 32'h8);
    rdc("unmapped", 8'h90, 32'h0);
    chk("link_l0", link_to_l0, 32'hff);
    wr(8'h0c, 32'h0001_0004);
    rdc("cmd", 8'h0c, 32'h0001_0004);
    wr(8'h00, 32'h3f);
    wr(8'h08, 32'h103);
    hpe_rc_model_i.enter_d3(3'd0);
    repeat (3) @(posedge clk);
    chk("link_d3", {link_to_l0[0], link_to_l1[0], l1_accept[0]}, 32'h3);
    // tlp dispositions in d3hot, one row per class
    for (int i = 0; i < 8; i++)
    begin
      hpe_rc_model_i.send(rows[i].k, 3'd0, act);
      chk("tlp_action", act, rows[i].a);
    end
    // wakeup without master enable, only on a fresh flag
    m = n_pme;
    ev(0, 3);
    ev(0, 3);
    chk("pme", n_pme - m, 32'h1);
    chk("pme_no_msi", n_msi, 32'h0);
    wr(8'h00, 32'h13f);
    m = n_msi;
    wr(8'h08, 32'h100);
    repeat (3) @(posedge clk);
    chk("msi_on_d0", n_msi - m, 32'h1);
    rdc("pm_d0", 8'h08, 32'h108);
    rdc("cmd_d0u", 8'h0c, 32'h0001_0000);
    // each slot flag raises an msi
    for (int k = 0; k < 6; k++)
    begin
      wr(8'h04, 32'h3f);
      m = n_msi;
      ev(0, k);
      chk("msi_flag", n_msi - m, 32'h1);
      rdc("slot_sts", 8'h04, 32'h1 << k);
    end
    wr(8'h04, 32'h3f);
    wr(8'h00, 32'h3f);
    m = n_msi;
    ev(0, 1);
    chk("master_off", n_msi - m, 32'h0);
    // intx on a port of partition 2
    wr(8'h1c, 32'h0200_0004);
    wr(8'h10, 32'h101);
    ev(1, 0);
    chk("intx_part", intx_part, 32'h4);
    wr(8'h14, 32'h1);
    wr(8'h1c, 32'h0200_0404);
    ev(1, 0);
    chk("intx_dis", intx_part, 32'h0);
    // legacy event on port 2 with the pin in alternate function
    wr(8'h88, 32'h1);
    wr(8'h80, 32'h6);
    wr(8'h2c, 32'h0001_0004);
    wr(8'h20, 32'h13f);
    m = n_msi;
    ev(2, 1);
    chk("legacy_pin", {legacy_event_out, gpio_pin_o, gpio_pin_oe}, 32'h7);
    chk("legacy_no_msi", n_msi - m, 32'h0);
    rdc("legacy_sts", 8'h84, 32'h4);
    rdc("slot_sts2", 8'h24, 32'h2);
    // upstream d3hot and turn-off
    up_fn_d3hot <= 1'b1;
    turnoff_acked <= 1'b1;
    repeat (2) @(posedge clk);
    rdc("sw_sts", 8'h8c, 32'h3);
    // reset in mid-run
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdc("pm_rst", 8'h08, 32'h8);
    rdc("cmd_rst", 8'h0c, 32'h0);
    final_report();
  end
endmodule
